// [rtl/sdlc_rx_params.svh]
// Purpose: constants of the frame-end CRC capture receiver
// Assumes: one bit strobe at most every fourth clock
// Notes:   definitions only
`ifndef SDLC_RX_PARAMS_SVH
`define SDLC_RX_PARAMS_SVH
`define FLAG_PATTERN     8'h7E
`define SYNC_BITS        7
`define PIPE_BITS        3
`define ONES_LIMIT       3'h5
`define SKIP_BITS        4'hA
`define LOST_BITS        2
`define FIFO_DEPTH       16
`define WORD_BITS        13
`define EXT_SEL_BIT      0
`define FULL_CRC_BIT     5
`define CHAR_LEN_BASE    4'h5
`endif

// [rtl/sdlc_rx_pkg.sv]
// Purpose: types of the frame-end CRC capture receiver
// Assumes: nothing
// Notes:   constants live in sdlc_rx_params.svh
package sdlc_rx_pkg;
   typedef enum logic [1:0] {ST_HUNT, ST_DATA, ST_FLUSH, ST_CLOSE} rx_state_t;
   typedef struct packed {
      logic       eof;
      logic [3:0] nbits;
      logic [7:0] data;
   } rx_word_t;
endpackage

// [rtl/rx_stream_if.sv]
// Purpose: valid/ready word stream between receiver modules
// Assumes: one clock domain
// Notes:   word is taken when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface rx_stream_if #(parameter int WIDTH = 13);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [rtl/rx_word_fifo.sv]
// Purpose: word buffer between character assembly and host side
// Assumes: depth is a power of two
// Notes:   full and empty come from a registered count
`timescale 1ns/1ps
`default_nettype none
module rx_word_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   rx_stream_if.snk  wr,
   rx_stream_if.src  rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp, rp, next_wp, next_rp;
   logic [AW:0]      cnt, next_cnt;
   logic             do_wr, do_rd;

   assign wr.ready = (cnt != DEPTH[AW:0]);
   assign rd.valid = (cnt != '0);
   assign rd.data  = mem[rp];

   always_comb begin
      do_wr    = wr.valid && wr.ready;
      do_rd    = rd.valid && rd.ready;
      next_wp  = do_wr ? wp + 1'b1 : wp;
      next_rp  = do_rd ? rp + 1'b1 : rp;
      next_cnt = cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end

   // storage needs no reset; only written words are ever read
   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[wp] <= wr.data;
      end
   end
endmodule
`default_nettype wire

// [rtl/sdlc_rx_front.sv]
// Purpose: sync-detect register, delay pipe and zero deletion
// Assumes: raw line bits arrive with a one-cycle strobe
// Notes:   deletion marks travel with each bit down the pipe
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_rx_params.svh"
module sdlc_rx_front (
   input  wire logic                   clk_i,
   input  wire logic                   rst_b_i,
   input  wire logic                   bit_en_i,
   input  wire logic                   bit_i,
   output logic                        flag_hit_o,
   output logic                        ingest_o,
   output logic [`PIPE_BITS-1:0]       pipe_o,
   output logic [`PIPE_BITS-1:0]       pipe_del_o
);
   logic [`SYNC_BITS-1:0] sync_bits, sync_del;
   logic [`SYNC_BITS-1:0] next_sync_bits, next_sync_del;
   logic [`PIPE_BITS-1:0] pipe, pipe_del, next_pipe, next_pipe_del;
   logic [2:0]            ones, next_ones;
   logic                  del_now;

   assign pipe_o     = pipe;
   assign pipe_del_o = pipe_del;

   always_comb begin
      // newest bit sits at the top, oldest leaves from bit 0
      flag_hit_o    = bit_en_i && ({bit_i, sync_bits} == `FLAG_PATTERN);
      del_now       = !bit_i && (ones == `ONES_LIMIT);
      ingest_o      = bit_en_i && !pipe_del[`PIPE_BITS-1];
      next_sync_bits = sync_bits;
      next_sync_del  = sync_del;
      next_pipe      = pipe;
      next_pipe_del  = pipe_del;
      next_ones      = ones;
      if (bit_en_i) begin
         next_sync_bits = {bit_i, sync_bits[`SYNC_BITS-1:1]};
         next_sync_del  = {del_now, sync_del[`SYNC_BITS-1:1]};
         // three bit times between sync register and shifter [RULE_02]
         next_pipe      = {pipe[`PIPE_BITS-2:0], sync_bits[0]};
         next_pipe_del  = {pipe_del[`PIPE_BITS-2:0], sync_del[0]};
         next_ones      = !bit_i ? 3'h0 : (ones == 3'h7 ? ones : ones + 3'h1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_bits <= '0;
         sync_del  <= '0;
         pipe      <= '0;
         pipe_del  <= '0;
         ones      <= '0;
      end else begin
         sync_bits <= next_sync_bits;
         sync_del  <= next_sync_del;
         pipe      <= next_pipe;
         pipe_del  <= next_pipe_del;
         ones      <= next_ones;
      end
   end

   pipe_delay_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      bit_en_i |=> pipe[0] == $past(sync_bits[0])) // [RULE_02]
      else $error("pipe stage did not take sync register output");
endmodule
`default_nettype wire

// [rtl/sdlc_rx_crc_capture.sv]
// Purpose: frame-end handling of the receive character assembler
// Assumes: bit strobes spaced at least four clocks; LSB first on line
// Notes:   one word per cycle into the buffer; overrun drops words
//
// Notes on behaviour
// RULE_01 - Without full CRC capture, a closing flag sends the shifter contents to the buffer whatever count they hold.
// RULE_02 - Bits reach the shifter three bit times after leaving the sync register.
// RULE_03 - Without full CRC capture the last two CRC bits never reach the buffer.
// RULE_04 - Full CRC capture is on only when both control bits are set to one.
// RULE_05 - With full CRC capture the last two CRC bits are shifted in before the final transfer.
// RULE_06 - Character boundaries and the final residue follow the chosen character length.
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_rx_params.svh"
module sdlc_rx_crc_capture (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        bit_en_i,
   input  wire logic        bit_i,
   input  wire logic [7:0]  extended_feature_control_reg_i,
   input  wire logic [7:0]  sdlc_enhancement_options_reg_i,
   input  wire logic [1:0]  char_len_i,
   input  wire logic        rx_ready_i,
   output logic             rx_valid_o,
   output logic [7:0]       rx_data_o,
   output logic [3:0]       rx_nbits_o,
   output logic             rx_eof_o,
   output logic             frame_done_o,
   output logic [3:0]       residue_o,
   output logic             overrun_o
);
   sdlc_rx_pkg::rx_state_t state, next_state;
   sdlc_rx_pkg::rx_word_t  push_word, pop_word;
   logic [7:0]  sr, next_sr;
   logic [3:0]  cnt, next_cnt;
   logic [3:0]  skip, next_skip;
   logic        flush_idx, next_flush_idx;
   logic        flag_hit, ingest;
   logic [`PIPE_BITS-1:0] pipe, pipe_del;
   logic        full_crc, shift_en, shift_bit, push_valid;
   logic [3:0]  char_len, grown;
   logic [7:0]  shifted;
   logic        next_valid, next_eof, next_done, next_overrun;
   logic [7:0]  next_data;
   logic [3:0]  next_nbits, next_residue;
   logic        pop_take;

   rx_stream_if #(.WIDTH(`WORD_BITS)) wr_if ();
   rx_stream_if #(.WIDTH(`WORD_BITS)) rd_if ();

   sdlc_rx_front u_front (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .bit_en_i   (bit_en_i),
      .bit_i      (bit_i),
      .flag_hit_o (flag_hit),
      .ingest_o   (ingest),
      .pipe_o     (pipe),
      .pipe_del_o (pipe_del)
   );

   rx_word_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .wr      (wr_if.snk),
      .rd      (rd_if.src)
   );

   // right-justify the n newest bits of the shifter
   function automatic logic [7:0] align(input logic [7:0] v,
                                        input logic [3:0] n);
      logic [3:0] gap;
      gap   = 4'h8 - n;
      align = v >> gap;
   endfunction

   always_comb begin
      full_crc = extended_feature_control_reg_i[`EXT_SEL_BIT]
               && sdlc_enhancement_options_reg_i[`FULL_CRC_BIT]; // [RULE_04]
      char_len = `CHAR_LEN_BASE + {2'b00, char_len_i};
   end

   always_comb begin
      next_state     = state;
      next_skip      = skip;
      next_flush_idx = flush_idx;
      shift_en       = 1'b0;
      shift_bit      = 1'b0;
      push_valid     = 1'b0;
      push_word      = '0;
      case (state)
         sdlc_rx_pkg::ST_HUNT: begin
            if (flag_hit) begin
               next_state = sdlc_rx_pkg::ST_DATA;
               next_skip  = `SKIP_BITS;
            end
         end
         sdlc_rx_pkg::ST_DATA: begin
            // flag bits still in the pipe are skipped, not assembled
            if (bit_en_i && skip != 4'h0) begin
               next_skip = skip - 4'h1;
            end else if (ingest) begin
               shift_en  = 1'b1;
               shift_bit = pipe[`PIPE_BITS-1];
            end
            if (flag_hit) begin
               if (skip != 4'h0) begin
                  next_skip = `SKIP_BITS;
               end else if (full_crc) begin
                  next_state     = sdlc_rx_pkg::ST_FLUSH; // [RULE_05]
                  next_flush_idx = 1'b0;
               end else begin
                  // the two newest CRC bits stay behind in the pipe [RULE_03]
                  next_state = sdlc_rx_pkg::ST_CLOSE; // [RULE_01]
               end
            end
         end
         sdlc_rx_pkg::ST_FLUSH: begin
            // pipe now holds the two CRC bits the legacy path drops
            shift_bit = flush_idx ? pipe[`LOST_BITS-1] : pipe[`LOST_BITS];
            shift_en  = flush_idx ? !pipe_del[`LOST_BITS-1]
                                  : !pipe_del[`LOST_BITS]; // [RULE_05]
            next_flush_idx = 1'b1;
            if (flush_idx) begin
               next_state = sdlc_rx_pkg::ST_CLOSE;
            end
         end
         sdlc_rx_pkg::ST_CLOSE: begin
            push_valid      = 1'b1;
            push_word.eof   = 1'b1;
            push_word.nbits = cnt;
            push_word.data  = align(sr, cnt); // [RULE_01]
            next_state      = sdlc_rx_pkg::ST_DATA;
            next_skip       = `SKIP_BITS;
         end
         default: begin
            next_state = sdlc_rx_pkg::ST_HUNT;
         end
      endcase
   end

   always_comb begin
      next_sr  = sr;
      next_cnt = cnt;
      shifted  = {shift_bit, sr[7:1]};
      grown    = cnt + 4'h1;
      if (state == sdlc_rx_pkg::ST_CLOSE || state == sdlc_rx_pkg::ST_HUNT) begin
         next_sr  = '0;
         next_cnt = '0;
      end else if (shift_en) begin
         next_sr  = shifted;
         next_cnt = grown;
         if (grown == char_len) begin
            next_cnt = '0; // [RULE_06]
         end
      end
   end

   // a completed character leaves in the cycle it fills
   sdlc_rx_pkg::rx_word_t char_word;
   logic                  char_push;
   always_comb begin
      char_push       = shift_en && (grown == char_len)
                      && state != sdlc_rx_pkg::ST_HUNT;
      char_word.eof   = 1'b0;
      char_word.nbits = char_len; // [RULE_06]
      char_word.data  = align(shifted, char_len);
      wr_if.valid     = push_valid || char_push;
      wr_if.data      = push_valid ? push_word : char_word;
   end

   always_comb begin
      pop_take     = !rx_valid_o || rx_ready_i;
      rd_if.ready  = pop_take;
      pop_word     = rd_if.data;
      next_valid   = rx_valid_o;
      next_data    = rx_data_o;
      next_nbits   = rx_nbits_o;
      next_eof     = rx_eof_o;
      // an empty buffer shows stale storage; keep it off the pins
      if (pop_take) begin
         next_valid = rd_if.valid;
         next_data  = rd_if.valid ? pop_word.data : 8'h00;
         next_nbits = rd_if.valid ? pop_word.nbits : 4'h0;
         next_eof   = pop_word.eof && rd_if.valid;
      end
      next_done    = push_valid;
      next_residue = push_valid ? cnt : residue_o;
      // a lost word sets the flag even when a close clears it
      next_overrun = (wr_if.valid && !wr_if.ready)
                   || (overrun_o && !(push_valid && wr_if.ready));
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state     <= sdlc_rx_pkg::ST_HUNT;
         skip      <= '0;
         flush_idx <= 1'b0;
         sr        <= '0;
         cnt       <= '0;
      end else begin
         state     <= next_state;
         skip      <= next_skip;
         flush_idx <= next_flush_idx;
         sr        <= next_sr;
         cnt       <= next_cnt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_valid_o   <= 1'b0;
         rx_data_o    <= '0;
         rx_nbits_o   <= '0;
         rx_eof_o     <= 1'b0;
         frame_done_o <= 1'b0;
         residue_o    <= '0;
         overrun_o    <= 1'b0;
      end else begin
         rx_valid_o   <= next_valid;
         rx_data_o    <= next_data;
         rx_nbits_o   <= next_nbits;
         rx_eof_o     <= next_eof;
         frame_done_o <= next_done;
         residue_o    <= next_residue;
         overrun_o    <= next_overrun;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   legacy_close_a: assert property ( // [RULE_01]
      (state == sdlc_rx_pkg::ST_DATA && flag_hit && skip == 4'h0 && !full_crc)
      |=> state == sdlc_rx_pkg::ST_CLOSE ##1 frame_done_o)
      else $error("legacy close did not transfer in two cycles");

   legacy_no_flush_a: assert property ( // [RULE_03]
      (state == sdlc_rx_pkg::ST_DATA && flag_hit && !full_crc)
      |=> state != sdlc_rx_pkg::ST_FLUSH)
      else $error("legacy close shifted extra CRC bits");

   crc_enable_a: assert property ( // [RULE_04]
      state == sdlc_rx_pkg::ST_FLUSH |-> full_crc)
      else $error("flush ran without both enable bits");

   full_crc_flush_a: assert property ( // [RULE_05]
      (state == sdlc_rx_pkg::ST_DATA && flag_hit && skip == 4'h0 && full_crc)
      |=> state == sdlc_rx_pkg::ST_FLUSH [*2] ##1
          state == sdlc_rx_pkg::ST_CLOSE ##1 frame_done_o)
      else $error("full CRC close did not flush two bits first");

   char_boundary_a: assert property ( // [RULE_06]
      char_push |=> cnt == 4'h0)
      else $error("character count not restarted after a push");

   residue_range_a: assert property ( // [RULE_06]
      frame_done_o |-> residue_o < char_len)
      else $error("residue not below character length");

   // a refused word must stay put until the host takes it
   hold_word_a: assert property (
      rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o)
         && $stable(rx_nbits_o) && $stable(rx_eof_o))
      else $error("output word changed before it was taken");

   overrun_set_a: assert property (
      (wr_if.valid && !wr_if.ready) |=> overrun_o)
      else $error("dropped word did not set overrun");

   overrun_clear_a: assert property (
      (push_valid && wr_if.ready) |=> !overrun_o)
      else $error("stored frame end did not clear overrun");

   done_pulse_a: assert property (
      frame_done_o |=> !frame_done_o)
      else $error("frame end pulse longer than one cycle");

   hunt_quiet_a: assert property (
      state == sdlc_rx_pkg::ST_HUNT |-> !wr_if.valid)
      else $error("word pushed before an opening flag");

   eof_only_close_a: assert property ( // [RULE_01]
      (wr_if.valid && wr_if.data[`WORD_BITS-1]) |->
         state == sdlc_rx_pkg::ST_CLOSE)
      else $error("frame end word outside the close state");

   nbits_range_a: assert property (
      rx_valid_o |-> rx_nbits_o <= 4'h8)
      else $error("word reports more than eight bits");

   legacy_close_c: cover property (
      state == sdlc_rx_pkg::ST_CLOSE && !full_crc);
   full_crc_close_c: cover property (
      state == sdlc_rx_pkg::ST_FLUSH ##2 frame_done_o);
   overrun_seen_c: cover property (overrun_o);
   flush_char_c: cover property (
      state == sdlc_rx_pkg::ST_FLUSH && char_push);
   host_stall_c: cover property (
      rx_valid_o && !rx_ready_i);
endmodule
`default_nettype wire

// [testbench/sdlc_tx_model.sv]
// Purpose: remote serial transmitter feeding raw line bits
// Assumes: frames loaded whole; one bit every fourth clock
// Notes:   line toggles while idle so a stale level is never trusted
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_rx_params.svh"
module sdlc_tx_model (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   output logic      bit_en_o,
   output logic      bit_o
);
   logic       line_q[$];
   logic [1:0] gap;

   // opening flag, stuffed payload, closing flag, lsb first
   task automatic load_frame(input logic p[$]);
      logic [7:0] flag;
      int         ones;
      flag = `FLAG_PATTERN;
      ones = 0;
      for (int i = 0; i < 8; i++)
         line_q.push_back(flag[i]);
      foreach (p[i]) begin
         line_q.push_back(p[i]);
         ones = p[i] ? ones + 1 : 0;
         if (ones == 5) begin
            line_q.push_back(1'b0);
            ones = 0;
         end
      end
      for (int i = 0; i < 8; i++)
         line_q.push_back(flag[i]);
   endtask

   // spacing of four clocks is the receiver's minimum
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gap      <= 2'h0;
         bit_en_o <= 1'b0;
         bit_o    <= 1'b1;
      end else begin
         gap      <= gap + 2'h1;
         bit_en_o <= 1'b0;
         if (gap == 2'h3 && line_q.size() > 0) begin
            bit_en_o <= 1'b1;
            bit_o    <= line_q.pop_front();
         end else if (gap == 2'h3) begin
            bit_o <= ~bit_o;
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench of the frame-end capture receiver
// Assumes: seed 60; host ready drawn at random
// Notes:   expected words built from the payload before it is sent
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_rx_params.svh"
module testbench;
   logic                   clk_i;
   logic                   rst_b_i;
   logic                   bit_en;
   logic                   bit_v;
   logic [7:0]             ext_reg;
   logic [7:0]             opt_reg;
   logic [1:0]             char_len;
   logic                   rx_ready;
   logic                   rx_valid;
   logic [7:0]             rx_data;
   logic [3:0]             rx_nbits;
   logic                   rx_eof;
   logic                   frame_done;
   logic [3:0]             residue;
   logic                   overrun;
   int                     failures;
   int                     tests_run;
   int                     seed;
   int                     frames_done;
   bit                     checking;
   bit                     hold_off;
   sdlc_rx_pkg::rx_word_t  exp_q[$];
   logic [3:0]             res_q[$];

   sdlc_rx_crc_capture i_sdlc_rx_crc_capture (
      .clk_i                          (clk_i),
      .rst_b_i                        (rst_b_i),
      .bit_en_i                       (bit_en),
      .bit_i                          (bit_v),
      .extended_feature_control_reg_i (ext_reg),
      .sdlc_enhancement_options_reg_i (opt_reg),
      .char_len_i                     (char_len),
      .rx_ready_i                     (rx_ready),
      .rx_valid_o                     (rx_valid),
      .rx_data_o                      (rx_data),
      .rx_nbits_o                     (rx_nbits),
      .rx_eof_o                       (rx_eof),
      .frame_done_o                   (frame_done),
      .residue_o                      (residue),
      .overrun_o                      (overrun)
   );

   sdlc_tx_model i_sdlc_tx_model (
      .clk_i    (clk_i),
      .rst_b_i  (rst_b_i),
      .bit_en_o (bit_en),
      .bit_o    (bit_v)
   );

   always #12.5 clk_i = ~clk_i;

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check_word(input sdlc_rx_pkg::rx_word_t got,
                             input sdlc_rx_pkg::rx_word_t exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check4(input logic [3:0] got, input logic [3:0] exp,
                         input string what);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t %s %h exp %h", $time, what, got, exp);
      end
   endtask

   // legacy mode loses payload bits among the last two line bits
   // (a stuffed zero there takes one slot); returns the residue
   function automatic logic [3:0] plan_words(input logic p[$],
                                             input int len, input bit full);
      sdlc_rx_pkg::rx_word_t w;
      int                    n;
      int                    ones;
      bit                    is_data[$];
      ones = 0;
      foreach (p[i]) begin
         is_data.push_back(1'b1);
         ones = p[i] ? ones + 1 : 0;
         if (ones == 5) begin
            is_data.push_back(1'b0);
            ones = 0;
         end
      end
      n = p.size();
      for (int k = 1; k <= `LOST_BITS; k++)
         if (!full)
            n = n - int'(is_data[is_data.size() - k]);
      w = '0;
      for (int i = 0; i < n; i++) begin
         w.data[w.nbits] = p[i];
         w.nbits++;
         if (w.nbits == len) begin
            exp_q.push_back(w);
            w = '0;
         end
      end
      w.eof = 1'b1;
      exp_q.push_back(w);
      return w.nbits;
   endfunction

   always @(posedge clk_i) begin
      rx_ready <= hold_off ? 1'b0 : (($random(seed) & 3) != 0);
      if (frame_done === 1'b1)
         frames_done++;
      if (rst_b_i && checking && rx_valid === 1'b1 && rx_ready === 1'b1) begin
         if (exp_q.size() > 0)
            check_word({rx_eof, rx_nbits, rx_data}, exp_q.pop_front());
         else
            check4(4'h1, 4'h0, "extra word");
      end
      if (checking && frame_done === 1'b1 && res_q.size() > 0)
         check4(residue, res_q.pop_front(), "residue");
   end

   // other control bits random save opt_reg[7:6] held at zero, so only the two enables may matter
   task automatic run_frame(input bit e, input bit f, input logic [1:0] len,
                            input int nb);
      logic p[$];
      int   done0;
      int   kept;
      @(posedge clk_i);
      ext_reg  <= {7'($random(seed) >> 1), e};
      opt_reg  <= {2'h0, f, 5'($random(seed))};
      char_len <= len;
      for (int i = 0; i < nb; i++)
         p.push_back(1'($random(seed)));
      res_q.push_back(plan_words(p, 5 + len, e & f));
      // a stalled host leaves every planned word queued
      kept  = checking ? 0 : exp_q.size();
      done0 = frames_done;
      i_sdlc_tx_model.load_frame(p);
      for (int t = 0; t < 5000; t++) begin
         @(posedge clk_i);
         if (frames_done != done0 && (exp_q.size() == 0 || !checking))
            break;
      end
      check4(4'(frames_done - done0), 4'h1, "frame ends");
      check4(4'(exp_q.size()), 4'(kept), "words left");
      exp_q.delete();
   endtask

   initial begin
      clk_i       = 1'b0;
      rst_b_i     = 1'b0;
      ext_reg     = 8'h00;
      opt_reg     = 8'h00;
      char_len    = 2'h0;
      rx_ready    = 1'b0;
      seed        = 60;
      failures    = 0;
      tests_run   = 0;
      frames_done = 0;
      checking    = 1'b1;
      hold_off    = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      check4({3'h0, overrun}, 4'h0, "overrun after reset");
      for (int m = 0; m < 4; m++)
         for (int l = 0; l < 4; l++)
            run_frame(m[0], m[1], 2'(l), 18 + ($random(seed) & 31));
      // whole characters only: frame-end word carries no bits
      run_frame(1'b1, 1'b1, 2'h3, 32);
      run_frame(1'b0, 1'b1, 2'h3, 34);
      // host stalls until the buffer refuses words
      hold_off = 1'b1;
      checking = 1'b0;
      run_frame(1'b1, 1'b1, 2'h0, 120);
      check4({3'h0, overrun}, 4'h1, "overrun set");
      hold_off = 1'b0;
      repeat (200) @(posedge clk_i);
      exp_q.delete();
      res_q.delete();
      checking = 1'b1;
      run_frame(1'b1, 1'b1, 2'h2, 30);
      check4({3'h0, overrun}, 4'h0, "overrun cleared");
      final_report();
   end

   // roughly eight times the expected run length
   initial begin
      #(25ns * 40000);
      failures++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report();
   end
endmodule
`default_nettype wire
